/* core/sfcc_defs.vh */
`ifndef SFCC_DEFS_VH
`define SFCC_DEFS_VH
// register byte offsets
`define SFCC_PROTO_OFS      8'h00
`define SFCC_SLAVE_OFS      8'h04
`define SFCC_BAUD_OFS       8'h08
`define SFCC_PARITY_OFS     8'h0C
`define SFCC_FRAME_OFS      8'h10
`define SFCC_ACC1_OFS       8'h14
`define SFCC_ACC2_OFS       8'h18
`define SFCC_IDENT_OFS      8'h1C
`define SFCC_FBADDR_OFS     8'h20
`define SFCC_FBMODE_OFS     8'h24
`define SFCC_KEYLOCK_OFS    8'h28
`define SFCC_TXDATA_OFS     8'h2C
`define SFCC_RXDATA_OFS     8'h30
`define SFCC_STATUS_OFS     8'h34
// protocol codes
`define SFCC_PROTO_OFF      2'h0
`define SFCC_PROTO_VENDOR   2'h1
`define SFCC_PROTO_ASCII    2'h2
`define SFCC_PROTO_RTU      2'h3
// parity codes
`define SFCC_PAR_NONE       2'h0
`define SFCC_PAR_ODD        2'h1
`define SFCC_PAR_EVEN       2'h2
// access codes
`define SFCC_ACC_RO         2'h0
`define SFCC_ACC_RW         2'h1
`define SFCC_ACC_RESTR      2'h2
// baud codes in tenths of kilobaud
`define SFCC_BAUD_4K8       9'h030
`define SFCC_BAUD_9K6       9'h060
`define SFCC_BAUD_19K2      9'h0C0
`define SFCC_BAUD_38K4      9'h180
// reset values and fieldbus address limits
`define SFCC_PROTO_RST      2'h1
`define SFCC_SLAVE_RST      17'h00001
`define SFCC_BAUD_RST       9'h060
`define SFCC_PARITY_RST     2'h0
`define SFCC_ACC_RST        2'h1
`define SFCC_IDENT_RST      1'h0
`define SFCC_FB_PA_RST      7'h7E
`define SFCC_FB_HART_RST    7'h00
`define SFCC_FB_PA_MIN      7'h01
`define SFCC_FB_PA_MAX      7'h7E
`define SFCC_FB_HART_MAX    7'h10
// frame format: data bits and stop bits
`define SFCC_DATA_BITS      4'h8
`define SFCC_STOP_BITS      4'h1
// bit times in 200 MHz clocks
`define SFCC_DIV_4K8        16'hA2C2
`define SFCC_DIV_9K6        16'h5161
`endif

/* core/sfcc_uart.v */
`timescale 1ns/10ps
`include "sfcc_defs.vh"
module sfcc_uart (
    // clock and reset
    input  wire        clk,
    input  wire        sys_rst,
    // settings
    input  wire        enable,
    input  wire [15:0] bit_cyc,
    input  wire [1:0]  parity_sel,
    // transmit
    input  wire        tx_start,
    input  wire [7:0]  tx_data,
    output reg         tx_busy_r,
    // receive
    output reg         rx_done_r,
    output reg  [7:0]  rx_data_r,
    output reg         rx_par_err_r,
    output reg         rx_frm_err_r,
    // line
    input  wire        rx_pin,
    output reg         tx_pin_r,
    output reg         tx_oe_r
);
    reg  [1:0]  rx_sync_r;
    reg  [15:0] tx_cnt_r;
    reg  [3:0]  tx_bit_r;
    reg  [10:0] tx_sh_r;
    reg  [15:0] rx_cnt_r;
    reg  [3:0]  rx_bit_r;
    reg  [9:0]  rx_sh_r;
    reg         rx_act_r;
    wire        par_on  = (parity_sel != `SFCC_PAR_NONE);
    wire [3:0]  last    = par_on ? 4'hA : 4'h9;
    wire        rx_line = rx_sync_r[1];

    function par_bit;
        input [7:0] d;
        input [1:0] sel;
        par_bit = (sel == `SFCC_PAR_ODD) ? ~(^d) : (^d);
    endfunction

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_sync_r <= 2'h3;
        end else begin
            rx_sync_r <= {rx_sync_r[0], rx_pin};
        end
    end

    // transmitter: start, 8 data lsb first, optional parity, 1 stop
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_busy_r <= 1'b0;
            tx_pin_r  <= 1'b1;
            tx_oe_r   <= 1'b0;
            tx_cnt_r  <= 16'h0000;
            tx_bit_r  <= 4'h0;
            tx_sh_r   <= 11'h7FF;
        end else if (!tx_busy_r) begin
            tx_pin_r <= 1'b1;
            tx_oe_r  <= 1'b0;
            if (tx_start && enable) begin
                tx_busy_r <= 1'b1;
                tx_oe_r   <= 1'b1;
                tx_pin_r  <= 1'b0;
                tx_cnt_r  <= bit_cyc;
                tx_bit_r  <= 4'h0;
                tx_sh_r   <= par_on ?
                    {1'b1, par_bit(tx_data, parity_sel), tx_data, 1'b0} :
                    {2'h3, tx_data, 1'b0};
            end
        end else if (tx_cnt_r > 16'h0001) begin
            tx_cnt_r <= tx_cnt_r - 16'h0001;
        end else if (tx_bit_r == last) begin
            // release the bus after the stop bit
            tx_busy_r <= 1'b0;
            tx_oe_r   <= 1'b0;
            tx_pin_r  <= 1'b1;
        end else begin
            tx_cnt_r <= bit_cyc;
            tx_bit_r <= tx_bit_r + 4'h1;
            tx_sh_r  <= {1'b1, tx_sh_r[10:1]};
            tx_pin_r <= tx_sh_r[1];
        end
    end

    // receiver samples mid bit; disabled port drops a frame being received, while a transmit in progress still finishes
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_act_r     <= 1'b0;
            rx_cnt_r     <= 16'h0000;
            rx_bit_r     <= 4'h0;
            rx_sh_r      <= 10'h000;
            rx_done_r    <= 1'b0;
            rx_data_r    <= 8'h00;
            rx_par_err_r <= 1'b0;
            rx_frm_err_r <= 1'b0;
        end else begin
            rx_done_r <= 1'b0;
            if (!enable) begin
                rx_act_r <= 1'b0;
            end else if (!rx_act_r) begin
                if (!rx_line) begin
                    rx_act_r <= 1'b1;
                    rx_cnt_r <= {1'b0, bit_cyc[15:1]};
                    rx_bit_r <= 4'h0;
                end
            end else if (rx_cnt_r > 16'h0001) begin
                rx_cnt_r <= rx_cnt_r - 16'h0001;
            end else if (rx_bit_r == 4'h0 && rx_line) begin
                // glitch, not a start bit
                rx_act_r <= 1'b0;
            end else if (rx_bit_r == last) begin
                rx_act_r     <= 1'b0;
                rx_done_r    <= 1'b1;
                rx_data_r    <= rx_sh_r[8:1];
                rx_frm_err_r <= ~rx_line;
                rx_par_err_r <= par_on &&
                    (rx_sh_r[9] != par_bit(rx_sh_r[8:1], parity_sel));
            end else begin
                rx_cnt_r <= bit_cyc;
                rx_bit_r <= rx_bit_r + 4'h1;
                rx_sh_r  <= par_on ? {rx_line, rx_sh_r[9:1]} :
                                     {1'b0, rx_line, rx_sh_r[8:1]};
            end
        end
    end
endmodule

/* core/sfcc_top.v */
// Operation
// - protocol select: off, vendor, ascii, rtu
// - baud in kilobaud: 4.8/9.6/19.2/38.4
// - any baud accepted, only listed supported
// - parity 0 none, 1 odd, 2 even
// - frame is eight data, one stop
// - access entry 1 serial, 2 fieldbus
// - access 0 ro, 1 rw, 2 restricted
// - remote write follows access entry only
// - keypad lock ignores modbus traffic
// - ident select 0 vendor, 1 profile
// - fieldbus address pa 1..126, hart 0..16
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`include "sfcc_defs.vh"
module sfcc_top (
    // clock and reset
    input  wire        clk,
    input  wire        sys_rst,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // rs-485 line
    input  wire        ser_rx,
    output wire        ser_tx,
    output wire        ser_tx_oe,
    // remote write permission check
    input  wire        rmt_wr_req,
    input  wire        rmt_port,
    input  wire        rmt_is_access,
    output reg         rmt_wr_grant_r,
    output reg         rmt_wr_deny_r,
    // settings seen by the rest of the device
    output reg  [1:0]  serial_protocol_select,
    output reg  [16:0] serial_slave_address,
    output reg         ident_number_select,
    output reg  [6:0]  fieldbus_address,
    output reg         fieldbus_hart_mode,
    output reg         keypad_lock
);
    reg  [8:0]  serial_baud_select;
    reg  [1:0]  serial_parity_select;
    reg  [1:0]  acc_serial_r;
    reg  [1:0]  acc_fbus_r;
    reg         rx_valid_r;
    reg  [7:0]  rx_hold_r;
    reg         overrun_r;
    reg         par_err_r;
    reg         frm_err_r;
    reg         tx_go_r;
    reg  [7:0]  tx_byte_r;
    reg  [31:0] rd_nxt;
    reg         map_nxt;
    wire        tx_busy;
    wire        rx_done;
    wire [7:0]  rx_data;
    wire        rx_par_err;
    wire        rx_frm_err;
    wire        port_on = (serial_protocol_select != `SFCC_PROTO_OFF);
    wire        acc_ph  = psel && penable;
    wire        wr_ok   = acc_ph && pready && pwrite;
    wire        rd_ok   = acc_ph && pready && !pwrite;
    wire        baud_ok = baud_supported(serial_baud_select);
    wire        addr_ok = (serial_slave_address != 17'h00000) &&
                          (serial_slave_address <= 17'h000F7);
    wire [15:0] bit_cyc = baud_cycles(serial_baud_select);
    wire [1:0]  acc_sel = rmt_port ? acc_fbus_r : acc_serial_r;
    wire        acc_first = acc_ph && !pready;
    wire        rx_rd   = rd_ok && (paddr == `SFCC_RXDATA_OFS);
    wire        st_wr   = wr_ok && (paddr == `SFCC_STATUS_OFS);
    wire        tx_wr   = wr_ok && (paddr == `SFCC_TXDATA_OFS);

    function baud_supported;
        input [8:0] b;
        baud_supported = (b == `SFCC_BAUD_4K8) || (b == `SFCC_BAUD_9K6) ||
                         (b == `SFCC_BAUD_19K2) || (b == `SFCC_BAUD_38K4);
    endfunction

    // unsupported codes run at 9600 so the port stays reachable
    function [15:0] baud_cycles;
        input [8:0] b;
        case (b)
            `SFCC_BAUD_4K8:  baud_cycles = `SFCC_DIV_4K8;
            `SFCC_BAUD_19K2: baud_cycles = `SFCC_DIV_9K6 >> 1;
            `SFCC_BAUD_38K4: baud_cycles = `SFCC_DIV_9K6 >> 2;
            default:         baud_cycles = `SFCC_DIV_9K6;
        endcase
    endfunction

    // code 3 is reserved in the parity and access selectors
    function code_ok;
        input [1:0] c;
        code_ok = (c != 2'h3);
    endfunction

    function fb_in_range;
        input       hart;
        input [6:0] a;
        fb_in_range = hart ? (a <= `SFCC_FB_HART_MAX) :
                      (a >= `SFCC_FB_PA_MIN && a <= `SFCC_FB_PA_MAX);
    endfunction

    // read mux
    // spare bits read as zero
    always @* begin
        rd_nxt  = 32'h00000000;
        map_nxt = 1'b1;
        case (paddr)
            `SFCC_PROTO_OFS:   rd_nxt[1:0]  = serial_protocol_select;
            `SFCC_SLAVE_OFS:   rd_nxt[16:0] = serial_slave_address;
            `SFCC_BAUD_OFS:    rd_nxt[8:0]  = serial_baud_select;
            `SFCC_PARITY_OFS:  rd_nxt[1:0]  = serial_parity_select;
            `SFCC_FRAME_OFS:   rd_nxt[7:0]  = {`SFCC_STOP_BITS,
                                               `SFCC_DATA_BITS};
            `SFCC_ACC1_OFS:    rd_nxt[1:0]  = acc_serial_r;
            `SFCC_ACC2_OFS:    rd_nxt[1:0]  = acc_fbus_r;
            `SFCC_IDENT_OFS:   rd_nxt[0]    = ident_number_select;
            `SFCC_FBADDR_OFS:  rd_nxt[6:0]  = fieldbus_address;
            `SFCC_FBMODE_OFS:  rd_nxt[0]    = fieldbus_hart_mode;
            `SFCC_KEYLOCK_OFS: rd_nxt[0]    = keypad_lock;
            `SFCC_TXDATA_OFS:  rd_nxt[7:0]  = tx_byte_r;
            `SFCC_RXDATA_OFS:  rd_nxt[7:0]  = rx_hold_r;
            `SFCC_STATUS_OFS:  rd_nxt[7:0]  = {addr_ok, baud_ok, frm_err_r,
                                               par_err_r, overrun_r,
                                               tx_busy, rx_valid_r,
                                               port_on};
            default:           map_nxt      = 1'b0;
        endcase
    end

    // apb: one wait state so read data comes from a flop
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc_first;
            pslverr <= acc_first && !map_nxt;
        end
    end

    // prdata holds until the next read
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= 32'h00000000;
        end else if (acc_first && !pwrite) begin
            prdata <= rd_nxt;
        end
    end

    // configuration registers; a write to an unmapped word is dropped
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            serial_protocol_select <= `SFCC_PROTO_RST;
            serial_slave_address   <= `SFCC_SLAVE_RST;
            serial_baud_select     <= `SFCC_BAUD_RST;
            serial_parity_select   <= `SFCC_PARITY_RST;
            acc_serial_r           <= `SFCC_ACC_RST;
            acc_fbus_r             <= `SFCC_ACC_RST;
            ident_number_select    <= `SFCC_IDENT_RST;
            fieldbus_address       <= `SFCC_FB_PA_RST;
            fieldbus_hart_mode     <= 1'b0;
            keypad_lock            <= 1'b0;
        end else if (wr_ok) begin
            case (paddr)
                `SFCC_PROTO_OFS:
                    serial_protocol_select <= pwdata[1:0];
                // full field kept; range is the installer's duty
                `SFCC_SLAVE_OFS:
                    serial_slave_address <= pwdata[16:0];
                `SFCC_BAUD_OFS:
                    serial_baud_select <= pwdata[8:0];
                `SFCC_PARITY_OFS:
                    if (code_ok(pwdata[1:0])) begin
                        serial_parity_select <= pwdata[1:0];
                    end
                `SFCC_ACC1_OFS:
                    if (code_ok(pwdata[1:0])) begin
                        acc_serial_r <= pwdata[1:0];
                    end
                `SFCC_ACC2_OFS:
                    if (code_ok(pwdata[1:0])) begin
                        acc_fbus_r <= pwdata[1:0];
                    end
                `SFCC_IDENT_OFS:
                    ident_number_select <= pwdata[0];
                `SFCC_FBADDR_OFS:
                    if (fb_in_range(fieldbus_hart_mode,
                                    pwdata[6:0]) &&
                        pwdata[31:7] == 25'h0000000) begin
                        fieldbus_address <= pwdata[6:0];
                    end
                `SFCC_FBMODE_OFS: begin
                    // mode change reloads that bus's default address
                    fieldbus_hart_mode <= pwdata[0];
                    if (pwdata[0] != fieldbus_hart_mode) begin
                        fieldbus_address <= pwdata[0] ?
                            `SFCC_FB_HART_RST : `SFCC_FB_PA_RST;
                    end
                end
                // local keypad only
                `SFCC_KEYLOCK_OFS:
                    keypad_lock <= pwdata[0];
                default: ;
            endcase
        end
    end

    // transmit request and receive holding
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_go_r    <= 1'b0;
            tx_byte_r  <= 8'h00;
            rx_valid_r <= 1'b0;
            rx_hold_r  <= 8'h00;
            overrun_r  <= 1'b0;
            par_err_r  <= 1'b0;
            frm_err_r  <= 1'b0;
        end else begin
            tx_go_r <= 1'b0;
            // busy drops the byte; poll tx_busy
            if (tx_wr && !tx_busy && port_on) begin
                tx_go_r   <= 1'b1;
                tx_byte_r <= pwdata[7:0];
            end
            // status flags clear on write of one; a new event wins
            if (st_wr) begin
                if (pwdata[3]) overrun_r <= 1'b0;
                if (pwdata[4]) par_err_r <= 1'b0;
                if (pwdata[5]) frm_err_r <= 1'b0;
            end
            if (rx_rd) begin
                rx_valid_r <= 1'b0;
            end
            if (rx_done) begin
                rx_valid_r <= 1'b1;
                rx_hold_r  <= rx_data;
                // newest character wins
                if (rx_valid_r && !rx_rd) begin
                    overrun_r <= 1'b1;
                end
                if (rx_par_err) par_err_r <= 1'b1;
                if (rx_frm_err) frm_err_r <= 1'b1;
            end
        end
    end

    // remote write check; keypad lock is deliberately not an input here
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rmt_wr_grant_r <= 1'b0;
            rmt_wr_deny_r  <= 1'b0;
        end else begin
            rmt_wr_grant_r <= 1'b0;
            rmt_wr_deny_r  <= 1'b0;
            if (rmt_wr_req) begin
                case (acc_sel)
                    `SFCC_ACC_RW:
                        rmt_wr_grant_r <= 1'b1;
                    `SFCC_ACC_RESTR: begin
                        rmt_wr_grant_r <= rmt_is_access;
                        rmt_wr_deny_r  <= !rmt_is_access;
                    end
                    // code 3 denies, the safe side
                    default:
                        rmt_wr_deny_r <= 1'b1;
                endcase
            end
        end
    end

    // settings act at once; change them idle
    sfcc_uart u_uart (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .enable       (port_on),
        .bit_cyc      (bit_cyc),
        .parity_sel   (serial_parity_select),
        .tx_start     (tx_go_r),
        .tx_data      (tx_byte_r),
        .tx_busy_r    (tx_busy),
        .rx_done_r    (rx_done),
        .rx_data_r    (rx_data),
        .rx_par_err_r (rx_par_err),
        .rx_frm_err_r (rx_frm_err),
        .rx_pin       (ser_rx),
        .tx_pin_r     (ser_tx),
        .tx_oe_r      (ser_tx_oe)
    );
endmodule

/* tb/sfcc_top_sva.sv */
`timescale 1ns/10ps
module sfcc_top_sva (
    // clock and reset
    input wire        clk,
    input wire        sys_rst,
    // apb
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    // line
    input wire        ser_tx,
    input wire        ser_tx_oe,
    // remote check
    input wire        rmt_wr_req,
    input wire        rmt_wr_grant_r,
    input wire        rmt_wr_deny_r,
    // settings
    input wire [1:0]  serial_protocol_select,
    input wire [6:0]  fieldbus_address,
    input wire        fieldbus_hart_mode
);
    wire proto_wr = psel && penable && pready && pwrite && paddr == 8'h00;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_one_wait: assert property (
        $rose(penable) && psel |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    a_err_unmapped: assert property (
        pready && pslverr |-> paddr > 8'h34)
        else $error("pslverr on a mapped address");
    a_frame_fixed: assert property (
        pready && !pwrite && paddr == 8'h10 |-> prdata == 32'h18)
        else $error("frame format word wrong");
    a_proto_by_write: assert property (
        $changed(serial_protocol_select) |-> $past(proto_wr))
        else $error("protocol changed without a write");
    a_remote_once: assert property (
        rmt_wr_req |=> rmt_wr_grant_r != rmt_wr_deny_r)
        else $error("remote request not answered once");
    a_remote_quiet: assert property (
        !$past(rmt_wr_req) |-> !(rmt_wr_grant_r || rmt_wr_deny_r))
        else $error("remote answer without request");
    a_off_silent: assert property (
        serial_protocol_select == 2'h0 && !ser_tx_oe |=> !ser_tx_oe)
        else $error("driver enabled while port off");
    a_idle_mark: assert property (
        !ser_tx_oe |-> ser_tx)
        else $error("line not at mark while idle");
    a_start_space: assert property (
        $rose(ser_tx_oe) |-> !ser_tx ##1 !ser_tx)
        else $error("frame does not open with start bit");
    a_fb_range: assert property (
        fieldbus_hart_mode ? fieldbus_address <= 7'h10
        : fieldbus_address >= 7'h01 && fieldbus_address <= 7'h7E)
        else $error("fieldbus address out of range");
endmodule

bind sfcc_top sfcc_top_sva u_sva (
    .clk                    (clk),
    .sys_rst                (sys_rst),
    .psel                   (psel),
    .penable                (penable),
    .pwrite                 (pwrite),
    .paddr                  (paddr),
    .prdata                 (prdata),
    .pready                 (pready),
    .pslverr                (pslverr),
    .ser_tx                 (ser_tx),
    .ser_tx_oe              (ser_tx_oe),
    .rmt_wr_req             (rmt_wr_req),
    .rmt_wr_grant_r         (rmt_wr_grant_r),
    .rmt_wr_deny_r          (rmt_wr_deny_r),
    .serial_protocol_select (serial_protocol_select),
    .fieldbus_address       (fieldbus_address),
    .fieldbus_hart_mode     (fieldbus_hart_mode)
);

/* tb/sfcc_rs485_master.sv */
`timescale 1ns/10ps
module sfcc_rs485_master #(
    parameter BIT_CYC = 5208
) (
    // clock
    input wire clk,
    // line
    input wire ser_tx,
    input wire ser_tx_oe,
    output reg ser_rx
);
    // failsafe bias pulls a released bus to mark
    wire       line = ser_tx_oe ? ser_tx : 1'b1;
    reg  [9:0] got_q[$];

    initial ser_rx = 1'b1;

    // same rate, parity and framing as the slave
    task send(input [7:0] d, input [1:0] par);
        reg [10:0] f;
        int        i;
        begin
            f = {1'b1, (par == 2'h1) ? ~^d : ^d, d, 1'b0};
            if (par == 2'h0) f[9] = 1'b1;
            @(posedge clk);
            for (i = 0; i < ((par == 2'h0) ? 10 : 11); i++) begin
                ser_rx <= f[i];
                repeat (BIT_CYC) @(posedge clk);
            end
        end
    endtask

    // mid-bit sampling: 8 data, parity, stop
    initial begin : rx_proc
        reg [9:0] b;
        int       i;
        forever begin
            @(posedge clk);
            if (line === 1'b0) begin
                repeat (BIT_CYC / 2) @(posedge clk);
                for (i = 0; i < 10; i++) begin
                    repeat (BIT_CYC) @(posedge clk);
                    b[i] = line;
                end
                got_q.push_back(b);
            end
        end
    end
endmodule

/* tb/serial_fieldbus_comm_config_bench.sv */
`timescale 1ns/10ps
module serial_fieldbus_comm_config_bench;
    reg         clk;
    reg         sys_rst;
    reg         psel;
    reg         penable;
    reg         pwrite;
    reg  [7:0]  paddr;
    reg  [31:0] pwdata;
    wire [31:0] prdata;
    wire        pready;
    wire        pslverr;
    wire        ser_rx;
    wire        ser_tx;
    wire        ser_tx_oe;
    reg         rmt_wr_req;
    reg         rmt_port;
    reg         rmt_is_access;
    wire        grant;
    wire        deny;
    wire [1:0]  proto;
    wire [16:0] slave;
    wire        ident;
    wire [6:0]  fbaddr;
    wire        hart;
    wire        klock;
    int         miscompares = 0;
    int         n_compared = 0;
    int         mdl[int];
    int         fb_v[6] = '{0, 1, 127, 126, 17, 16};
    int         bd_v[5] = '{48, 96, 192, 50, 384};
    int         sa_v[4] = '{0, 247, 248, 1};
    integer     seed = 32'h10BC59C0;
    reg  [31:0] rd;
    reg         er;
    reg  [7:0]  tx_b;
    reg  [7:0]  rx_b;
    reg  [9:0]  g;
    int         i;
    int         n;

    sfcc_top dut (
        .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ser_rx(ser_rx),
        .ser_tx(ser_tx), .ser_tx_oe(ser_tx_oe), .rmt_wr_req(rmt_wr_req),
        .rmt_port(rmt_port), .rmt_is_access(rmt_is_access),
        .rmt_wr_grant_r(grant), .rmt_wr_deny_r(deny),
        .serial_protocol_select(proto), .serial_slave_address(slave),
        .ident_number_select(ident), .fieldbus_address(fbaddr),
        .fieldbus_hart_mode(hart), .keypad_lock(klock)
    );

    sfcc_rs485_master #(.BIT_CYC(5208)) u_far (
        .clk(clk), .ser_tx(ser_tx), .ser_tx_oe(ser_tx_oe), .ser_rx(ser_rx)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task summarize;
        begin
            $display("compared %0d mismatched %0d", n_compared, miscompares);
            if (miscompares == 0 && n_compared > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask

    task chk(input string what, input [31:0] exp, input [31:0] got);
        begin
            n_compared++;
            if (got !== exp) begin
                miscompares++;
                $display("mismatch %s expected %h seen %h", what, exp, got);
            end
        end
    endtask

    // request held until pready is seen at an edge
    task apb(input w, input [7:0] a, input [31:0] d);
        int k;
        begin
            @(posedge clk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            penable <= 1'b1;
            k = 0;
            do begin
                @(posedge clk);
                k++;
            end while (pready !== 1'b1 && k < 50);
            if (k >= 50) begin
                miscompares++;
                summarize;
            end
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task wr(input [7:0] a, input [31:0] d);
        begin
            apb(1'b1, a, d);
            @(posedge clk);
            chk("write error", a > 8'h34, er);
            case (a)
                8'h0C, 8'h14, 8'h18: if (d[1:0] != 2'h3) mdl[a] = d;
                8'h20: if (mdl[8'h24] ? d <= 16 : d >= 1 && d <= 126)
                    mdl[a] = d;
                8'h24: begin
                    if (d[0] != mdl[a]) mdl[8'h20] = d[0] ? 0 : 126;
                    mdl[a] = d[0];
                end
                default: if (mdl.exists(a) && a != 8'h10 && a < 8'h2C)
                    mdl[a] = d;
            endcase
        end
    endtask

    task rdchk(input [7:0] a);
        begin
            apb(1'b0, a, 32'h0);
            chk($sformatf("reg %h", a), mdl.exists(a) ? mdl[a] : 0, rd);
            chk("read error", !mdl.exists(a), er);
        end
    endtask

    initial begin
        {sys_rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
        {rmt_wr_req, rmt_port, rmt_is_access} = 3'h0;
        mdl = '{0:1, 4:1, 8:'h60, 'hC:0, 'h10:'h18, 'h14:1, 'h18:1,
                'h1C:0, 'h20:126, 'h24:0, 'h28:0, 'h2C:0, 'h30:0, 'h34:'hC1};
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        for (i = 0; i <= 'h3C; i += 4) rdchk(8'(i));
        for (i = 0; i < 4; i++) begin
            wr(8'h00, i);
            chk("protocol", i, proto);
            wr(8'h0C, i);
            rdchk(8'h0C);
            wr(8'h14, i);
            wr(8'h18, 3 - i);
            rdchk(8'h14);
            rdchk(8'h18);
        end
        wr(8'h10, 0);
        rdchk(8'h10);
        wr(8'h1C, 1);
        rdchk(8'h1C);
        chk("ident", 1, ident);
        foreach (fb_v[i]) begin
            if (i == 4) wr(8'h24, 1);
            wr(8'h20, fb_v[i]);
            rdchk(8'h20);
            chk("fieldbus", mdl[8'h20], fbaddr);
        end
        wr(8'h24, 0);
        rdchk(8'h20);
        foreach (bd_v[i]) begin
            wr(8'h08, bd_v[i]);
            rdchk(8'h08);
            apb(1'b0, 8'h34, 0);
            chk("baud ok", bd_v[i] != 50, rd[6]);
        end
        sa_v[3] = $unsigned($random(seed)) % 100000;
        foreach (sa_v[i]) begin
            wr(8'h04, sa_v[i]);
            chk("slave", sa_v[i], slave);
            apb(1'b0, 8'h34, 0);
            chk("addr ok", sa_v[i] >= 1 && sa_v[i] <= 247, rd[7]);
        end
        // keypad lock flips every pass and must never matter
        for (i = 0; i < 24; i++) begin
            wr(8'h28, i % 2);
            chk("keypad", i % 2, klock);
            wr(i & 2 ? 8'h18 : 8'h14, i / 8);
            rmt_port <= i[1];
            rmt_is_access <= i[2];
            rmt_wr_req <= 1'b1;
            @(posedge clk);
            rmt_wr_req <= 1'b0;
            @(posedge clk);
            chk("grant", i / 8 == 1 || (i / 8 == 2 && i[2]), grant);
            chk("deny", !(i / 8 == 1 || (i / 8 == 2 && i[2])), deny);
        end
        wr(8'h04, 1);
        wr(8'h00, 3);
        wr(8'h08, 384);
        wr(8'h0C, 2);
        tx_b = $random(seed);
        rx_b = $random(seed);
        wr(8'h2C, tx_b);
        fork
            u_far.send(rx_b, 2'h2);
            for (n = 0; n < 70000 && u_far.got_q.size() == 0; n++)
                @(posedge clk);
        join
        if (u_far.got_q.size() == 0) begin
            miscompares++;
            summarize;
        end
        g = u_far.got_q.pop_front();
        chk("tx frame", {1'b1, ^tx_b, tx_b}, g);
        apb(1'b0, 8'h34, 0);
        chk("rx status", 6'h03, rd[5:0]);
        apb(1'b0, 8'h30, 0);
        chk("rx data", rx_b, rd[7:0]);
        wr(8'h00, 0);
        wr(8'h2C, 8'hA5);
        repeat (20) @(posedge clk);
        chk("off enable", 0, ser_tx_oe);
        summarize;
    end
endmodule
